// [logic/nvr_frontend.sv]
// SPI slave front-end of a serial NV-SRAM: framing, recall engine, save enable.
// Assumes pins are asynchronous to clk_sys and SCK is well below clk_sys / 8.
module nvr_frontend
    import nvr_pkg::*;
#(
    parameter int PWRUP_CYC = PWRUP_RECALL_CYC,  // Power-up recall length
    parameter int SWREC_CYC = SW_RECALL_CYC      // Software recall length
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              spi_cs_n,
    input  wire logic              spi_sck,
    input  wire logic              spi_si,
    output logic                   spi_so,
    output logic                   spi_so_oe,
    output logic                   store_busy_pin_o,
    output logic                   store_busy_pin_oe,
    output logic                   busy_flag,
    output logic                   spi_mode3,
    input  wire logic              autosave_nv,
    output logic                   autosave_en,
    input  wire logic              power_fail,
    output logic                   autosave_start,
    output logic                   recall_clear,
    output logic                   recall_copy,
    output logic                   mem_rd_req,
    output logic      [ADDR_W-1:0] mem_rd_addr,
    input  wire logic [7:0]        mem_rd_data,
    output logic                   mem_wr_valid,
    input  wire logic              mem_wr_ready,
    output logic      [ADDR_W-1:0] mem_wr_addr,
    output logic      [7:0]        mem_wr_data,
    output logic                   wr_overflow
);

    // Synchronised pins
    logic cs_n_s, sck_s, si_s, pf_s;
    logic cs_n_p_q, sck_p_q, pf_p_q;  // Previous samples for edges
    logic cs_fall, sck_rise, sck_fall;

    nvr_sync #(.W(4), .INIT(4'h8)) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       ({spi_cs_n, spi_sck, spi_si, power_fail}),
        .q       ({cs_n_s, sck_s, si_s, pf_s})
    );

    // Edge detection works on synchronised copies only
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cs_n_p_q <= 1'b1;
            sck_p_q  <= 1'b0;
            pf_p_q   <= 1'b0;
        end
        else
        begin
            cs_n_p_q <= cs_n_s;
            sck_p_q  <= sck_s;
            pf_p_q   <= pf_s;
        end
    end

    assign cs_fall  = cs_n_p_q && !cs_n_s;
    assign sck_rise = !sck_p_q && sck_s && !cs_n_s;
    assign sck_fall = sck_p_q && !sck_s && !cs_n_s;

    // Write path FIFO
    nvr_stream_if #(.W(FIFO_W)) wr_in ();
    nvr_stream_if #(.W(FIFO_W)) wr_out ();

    nvr_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys (clk_sys),
        .rst     (rst),
        .in_s    (wr_in.snk),
        .out_s   (wr_out.src)
    );

    // Serial framing state
    nvr_spi_st_t       st_q, st_d;
    logic [2:0]        bit_q, bit_d;        // Bit within byte
    logic [7:0]        sh_q, sh_d;          // Receive shifter
    logic [7:0]        tx_q, tx_d;          // Transmit shifter
    logic [ADDR_W-1:0] addr_q, addr_d;      // Current memory address
    logic              abyte_q, abyte_d;    // Second address byte pending
    logic              rd_op_q, rd_op_d;    // Opcode was a read
    logic              mode3_q, mode3_d;
    logic              rose_q, rose_d;      // A rising edge seen this frame
    logic              so_q, so_d;
    logic              so_oe_q, so_oe_d;
    logic              rd_req_q, rd_req_d;
    logic              rd_ld_q, rd_ld_d;    // Read data lands this cycle
    logic              push_q, push_d;
    logic [FIFO_W-1:0] word_q, word_d;
    logic              ovf_q, ovf_d;
    logic              rc_go, en_cmd, dis_cmd;
    logic [7:0]        rx;
    logic              rc_busy;

    assign rx = {sh_q[6:0], si_s};

    // Framing next state
    always_comb
    begin
        st_d     = st_q;
        bit_d    = bit_q;
        sh_d     = sh_q;
        tx_d     = tx_q;
        addr_d   = addr_q;
        abyte_d  = abyte_q;
        rd_op_d  = rd_op_q;
        mode3_d  = mode3_q;
        rose_d   = rose_q;
        so_d     = so_q;
        so_oe_d  = so_oe_q;
        rd_req_d = 1'b0;
        rd_ld_d  = rd_req_q;
        push_d   = 1'b0;
        word_d   = word_q;
        ovf_d    = ovf_q || (push_q && !wr_in.ready);
        rc_go    = 1'b0;
        en_cmd   = 1'b0;
        dis_cmd  = 1'b0;
        // Read data from memory arrives one cycle after the request
        if (rd_ld_q)
        begin
            tx_d   = mem_rd_data;
            addr_d = addr_q + 1'b1;
        end
        if (cs_n_s)
        begin
            // Deselected: nothing shifts, output released
            st_d    = NVR_IDLE;
            so_oe_d = 1'b0;
        end
        else if (cs_fall)
        begin
            st_d    = NVR_OPC;
            bit_d   = 3'h0;
            mode3_d = sck_s;
            rose_d  = 1'b0;
            so_oe_d = 1'b0;
        end
        else
        begin
            if (sck_rise)
            begin
                // Sample on rising edges only
                rose_d = 1'b1;
                sh_d   = rx;
                bit_d  = bit_q + 3'h1;
                if (bit_q == 3'h7)
                begin
                    unique case (st_q)
                        NVR_OPC:
                        begin
                            // First byte is the opcode
                            if (rc_busy)
                                st_d = NVR_IGNORE;
                            else if (rx == OP_RECALL)
                            begin
                                rc_go = 1'b1;
                                st_d  = NVR_DONE;
                            end
                            else if (rx == OP_SAVE_EN)
                            begin
                                en_cmd = 1'b1;
                                st_d   = NVR_DONE;
                            end
                            else if (rx == OP_SAVE_DIS)
                            begin
                                dis_cmd = 1'b1;
                                st_d    = NVR_DONE;
                            end
                            else if (rx == OP_READ || rx == OP_WRITE)
                            begin
                                rd_op_d = (rx == OP_READ);
                                abyte_d = 1'b0;
                                st_d    = NVR_ADDR;
                            end
                            else
                                st_d = NVR_IGNORE;
                        end
                        NVR_ADDR:
                        begin
                            // Two address bytes, high first
                            addr_d  = {addr_q[7:0], rx};
                            abyte_d = 1'b1;
                            if (abyte_q)
                            begin
                                st_d     = rd_op_q ? NVR_RDATA : NVR_WDATA;
                                rd_req_d = rd_op_q;
                            end
                        end
                        NVR_RDATA:
                            rd_req_d = 1'b1;  // Prefetch next burst byte
                        NVR_WDATA:
                        begin
                            // Address wraps at top of array
                            push_d = 1'b1;
                            word_d = {addr_q, rx};
                            addr_d = addr_q + 1'b1;
                        end
                        default:
                        begin
                            // Idle, done, ignore: one opcode per select
                        end
                    endcase
                end
            end
            // Shift out on falling edges after the first counted rise
            if (sck_fall && rose_q && st_q == NVR_RDATA)
            begin
                so_d    = tx_q[7];
                tx_d    = {tx_q[6:0], 1'b0};
                so_oe_d = 1'b1;
            end
        end
    end

    // Framing registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_q     <= NVR_IDLE;
            bit_q    <= 3'h0;
            sh_q     <= 8'h00;
            tx_q     <= 8'h00;
            addr_q   <= '0;
            abyte_q  <= 1'b0;
            rd_op_q  <= 1'b0;
            mode3_q  <= 1'b0;
            rose_q   <= 1'b0;
            so_q     <= 1'b0;
            so_oe_q  <= 1'b0;
            rd_req_q <= 1'b0;
            rd_ld_q  <= 1'b0;
            push_q   <= 1'b0;
            word_q   <= '0;
            ovf_q    <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            bit_q    <= bit_d;
            sh_q     <= sh_d;
            tx_q     <= tx_d;
            addr_q   <= addr_d;
            abyte_q  <= abyte_d;
            rd_op_q  <= rd_op_d;
            mode3_q  <= mode3_d;
            rose_q   <= rose_d;
            so_q     <= so_d;
            so_oe_q  <= so_oe_d;
            rd_req_q <= rd_req_d;
            rd_ld_q  <= rd_ld_d;
            push_q   <= push_d;
            word_q   <= word_d;
            ovf_q    <= ovf_d;
        end
    end

    // Full FIFO drops the byte; the sticky flag tells the host
    assign wr_in.valid  = push_q;
    assign wr_in.data   = word_q;
    assign wr_out.ready = mem_wr_ready;

    // Recall engine: one up-counter, clear phase then copy phase
    nvr_rc_st_t  rc_q, rc_d;
    logic [15:0] rc_cnt_q, rc_cnt_d;
    logic [15:0] rc_lim_q, rc_lim_d;
    logic        clr_q, clr_d, cpy_q, cpy_d;
    logic        busy_q, busy_d;        // Own flop so pin and flag leave a register

    assign rc_busy = (rc_q == NVR_RC_RUN);

    // Recall next state
    always_comb
    begin
        rc_d     = rc_q;
        rc_cnt_d = rc_cnt_q;
        rc_lim_d = rc_lim_q;
        if (rc_q == NVR_RC_RUN)
        begin
            // Timer holds access off until expiry
            rc_cnt_d = rc_cnt_q + 16'h0001;
            if (rc_cnt_q == rc_lim_q - 16'h0001)
                rc_d = NVR_RC_IDLE;
        end
        else if (rc_go)
        begin
            rc_d     = NVR_RC_RUN;
            rc_cnt_d = 16'h0000;
            rc_lim_d = 16'(SWREC_CYC);
        end
        // Zero the array first, then copy NV into SRAM only
        clr_d = (rc_d == NVR_RC_RUN) && (rc_cnt_d < CLEAR_CYC);
        cpy_d = (rc_d == NVR_RC_RUN) && (rc_cnt_d >= CLEAR_CYC);
        busy_d = clr_d || cpy_d;
    end

    // Reset is power-up: recall always starts, nothing can mask it
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rc_q     <= NVR_RC_RUN;
            rc_cnt_q <= 16'h0000;
            rc_lim_q <= 16'(PWRUP_CYC);
            clr_q    <= 1'b1;
            cpy_q    <= 1'b0;
            busy_q   <= 1'b1;
        end
        else
        begin
            rc_q     <= rc_d;
            rc_cnt_q <= rc_cnt_d;
            rc_lim_q <= rc_lim_d;
            clr_q    <= clr_d;
            cpy_q    <= cpy_d;
            busy_q   <= busy_d;
        end
    end

    // Automatic save enable: volatile, reloaded from stored copy
    logic save_en_q, save_en_d;
    logic loaded_q, loaded_d;   // Stored copy taken after power-up
    logic as_start_q, as_start_d;

    // Save enable next state
    always_comb
    begin
        loaded_d   = 1'b1;
        save_en_d  = save_en_q;
        if (!loaded_q)
            save_en_d = autosave_nv;
        else if (en_cmd)
            save_en_d = 1'b1;
        else if (dis_cmd)
            save_en_d = 1'b0;
        // Power-down save only fires when enabled
        as_start_d = pf_s && !pf_p_q && save_en_q;
    end

    // Save enable registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            save_en_q  <= SAVE_EN_RST;
            loaded_q   <= 1'b0;
            as_start_q <= 1'b0;
        end
        else
        begin
            save_en_q  <= save_en_d;
            loaded_q   <= loaded_d;
            as_start_q <= as_start_d;
        end
    end

    // Outputs
    assign spi_so            = so_q;
    assign spi_so_oe         = so_oe_q;
    assign store_busy_pin_o  = 1'b0;          // Open drain: only pulls low
    assign store_busy_pin_oe = busy_q;
    assign busy_flag         = busy_q;
    assign spi_mode3         = mode3_q;
    assign autosave_en       = save_en_q;
    assign autosave_start    = as_start_q;
    assign recall_clear      = clr_q;
    assign recall_copy       = cpy_q;
    assign mem_rd_req        = rd_req_q;
    assign mem_rd_addr       = addr_q;
    assign mem_wr_valid      = wr_out.valid;
    assign mem_wr_addr       = wr_out.data[FIFO_W-1:8];
    assign mem_wr_data       = wr_out.data[7:0];
    assign wr_overflow       = ovf_q;

endmodule

// [logic/nvr_pkg.sv]
// Shared constants and types for the serial NV-SRAM front-end.
// Assumes a single 100 MHz system clock; all SPI pins are asynchronous.
package nvr_pkg;

    // System clock
    localparam int CLK_NS = 10;

    // Recall durations (ns); least times, so counts round up
    localparam int PWRUP_RECALL_NS  = 20000;
    localparam int SW_RECALL_NS     = 2000;
    localparam int PWRUP_RECALL_CYC = (PWRUP_RECALL_NS + CLK_NS - 1) / CLK_NS;
    localparam int SW_RECALL_CYC    = (SW_RECALL_NS + CLK_NS - 1) / CLK_NS;

    // Cycles spent zeroing the array before the copy phase
    localparam logic [15:0] CLEAR_CYC = 16'h0010;

    // Opcodes
    localparam logic [7:0] OP_RECALL   = 8'h60;
    localparam logic [7:0] OP_SAVE_EN  = 8'h59;
    localparam logic [7:0] OP_SAVE_DIS = 8'h19;
    localparam logic [7:0] OP_READ     = 8'h03;
    localparam logic [7:0] OP_WRITE    = 8'h02;

    // Widths and depths
    localparam int ADDR_W     = 16;
    localparam int FIFO_W     = 24;
    localparam int FIFO_DEPTH = 4;

    // Reset values
    localparam logic SAVE_EN_RST = 1'b1;

    // Serial framing states
    typedef enum logic [2:0] {
        NVR_IDLE,
        NVR_OPC,
        NVR_ADDR,
        NVR_RDATA,
        NVR_WDATA,
        NVR_DONE,
        NVR_IGNORE
    } nvr_spi_st_t;

    // Recall engine states
    typedef enum logic {
        NVR_RC_IDLE,
        NVR_RC_RUN
    } nvr_rc_st_t;

endpackage

// [logic/nvr_stream_if.sv]
// Valid/ready stream carrier between the front-end and its FIFO.
// Assumes source and sink share one clock.
interface nvr_stream_if #(parameter int W = 8);
    logic         valid;   // Word offered
    logic         ready;   // Word accepted
    logic [W-1:0] data;    // Payload

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [logic/nvr_sync.sv]
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence.
module nvr_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;   // First stage, read only by the second

    // Plain double register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= INIT;
            q      <= INIT;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// [logic/nvr_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two.
module nvr_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  wire logic   clk_sys,
    input  wire logic   rst,
    nvr_stream_if.snk   in_s,
    nvr_stream_if.src   out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];   // Storage
    logic [AW:0]  wp_q, wp_d;      // Write pointer, wrap bit on top
    logic [AW:0]  rp_q, rp_d;      // Read pointer
    logic         full, empty;

    assign full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty = (wp_q == rp_q);
    assign in_s.ready  = !full;
    assign out_s.valid = !empty;
    assign out_s.data  = mem_q[rp_q[AW-1:0]];

    // Pointer advance
    always_comb
    begin
        wp_d = wp_q;
        rp_d = rp_q;
        if (in_s.valid && !full)
            wp_d = wp_q + 1'b1;
        if (out_s.ready && !empty)
            rp_d = rp_q + 1'b1;
    end

    // Pointers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    // Storage has no reset; empty flag hides stale words
    always_ff @(posedge clk_sys)
    begin
        if (in_s.valid && !full)
            mem_q[wp_q[AW-1:0]] <= in_s.data;
    end
endmodule

// [verification/nvr_frontend_checker.sv]
// Port-level checks for the NV-SRAM front-end.
// Assumes one clk_sys domain; rst stands for power-up.
module nvr_frontend_checker
    import nvr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic spi_cs_n,
    input wire logic spi_so_oe,
    input wire logic store_busy_pin_o,
    input wire logic store_busy_pin_oe,
    input wire logic busy_flag,
    input wire logic autosave_en,
    input wire logic autosave_start,
    input wire logic recall_clear,
    input wire logic recall_copy,
    input wire logic mem_rd_req
);
    timeunit 1ns;
    timeprecision 100ps;

    // Single domain, reset masks everything
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_busy_pin;
        busy_flag |-> store_busy_pin_oe && !store_busy_pin_o;
    endproperty
    a_busy_pin: assert property (p_busy_pin)
        else $error("busy pin not pulled low while busy");

    property p_phase;
        (recall_clear || recall_copy) == busy_flag;
    endproperty
    a_phase: assert property (p_phase)
        else $error("busy and recall phases disagree");

    property p_clear_first;
        $rose(recall_copy) |-> $past(recall_clear) && !recall_clear;
    endproperty
    a_clear_first: assert property (p_clear_first)
        else $error("copy phase without clear phase before it");

    property p_copy_end;
        $fell(busy_flag) |-> $past(recall_copy);
    endproperty
    a_copy_end: assert property (p_copy_end)
        else $error("recall ended outside copy phase");

    // Clear phase lasts sixteen cycles, so eight is a safe floor
    property p_sw_start;
        $rose(busy_flag) |-> recall_clear [*8];
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("recall did not open with clear phase");

    property p_no_rd;
        busy_flag |-> !mem_rd_req;
    endproperty
    a_no_rd: assert property (p_no_rd)
        else $error("memory read during recall");

    // Sync lag is two or three cycles, six leaves margin
    property p_so_off;
        spi_cs_n [*6] |-> !spi_so_oe;
    endproperty
    a_so_off: assert property (p_so_off)
        else $error("serial out driven while deselected");

    property p_save_gate;
        autosave_start |-> $past(autosave_en);
    endproperty
    a_save_gate: assert property (p_save_gate)
        else $error("power-down save started while disabled");
endmodule

bind nvr_frontend nvr_frontend_checker nvr_frontend_checker_i (
    .clk_sys, .rst, .spi_cs_n, .spi_so_oe, .store_busy_pin_o, .store_busy_pin_oe,
    .busy_flag, .autosave_en, .autosave_start, .recall_clear, .recall_copy, .mem_rd_req
);

// [verification/nvr_spi_master.sv]
// Behavioural SPI bus master driving the front-end pins.
// Assumes the bench calls frame(); SCK period 125 ns.
module nvr_spi_master (
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    // Deselected, mode 0 idle level
    initial
    begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end

    // One select period of n bytes; rx holds the last byte seen on SO
    task automatic frame(input logic m3, input logic [63:0] v, input int n,
                         output logic [7:0] rx);
        sck = m3;
        #100 cs_n = 1'b0;
        for (int i = 8 * n - 1; i >= 0; i--)
        begin
            #31 sck = 1'b0;
            si = v[i];
            #62.5 sck = 1'b1;
            rx = {rx[6:0], so_oe ? so : 1'bx};     // Undriven SO never matches
            #31.5;
        end
        #31 sck = m3;
        #100 cs_n = 1'b1;
        si = ~si;                                  // Released line inverts last bit
        #300;
    endtask
endmodule

// [verification/testbench.sv]
// Self-checking bench for the NV-SRAM front-end.
// Assumes nvr_spi_master as SPI host and a byte memory model here.
module testbench
    import nvr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic              clk_sys, rst, spi_cs_n, spi_sck, spi_si, spi_so, spi_so_oe;
    logic              store_busy_pin_o, store_busy_pin_oe, busy_flag, spi_mode3;
    logic              autosave_nv, autosave_en, power_fail, autosave_start;
    logic              recall_clear, recall_copy, mem_rd_req, mem_wr_valid;
    logic              mem_wr_ready, wr_overflow, oe_seen;
    logic [ADDR_W-1:0] mem_rd_addr, mem_wr_addr, a;
    logic [7:0]        mem_rd_data, mem_wr_data, rx;
    logic [15:0]       ops [3] = '{16'h0019, 16'h0059, 16'h5919};
    int                n_errors, samples_checked, cnt, run, last_run;

    nvr_frontend #(.PWRUP_CYC(40), .SWREC_CYC(200)) nvr_frontend_i (
        .clk_sys, .rst, .spi_cs_n, .spi_sck, .spi_si, .spi_so, .spi_so_oe,
        .store_busy_pin_o, .store_busy_pin_oe, .busy_flag, .spi_mode3,
        .autosave_nv, .autosave_en, .power_fail, .autosave_start, .recall_clear,
        .recall_copy, .mem_rd_req, .mem_rd_addr, .mem_rd_data, .mem_wr_valid,
        .mem_wr_ready, .mem_wr_addr, .mem_wr_data, .wr_overflow
    );
    nvr_spi_master nvr_spi_master_i (.cs_n(spi_cs_n), .sck(spi_sck), .si(spi_si),
        .so(spi_so), .so_oe(spi_so_oe));

    // 100 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Read port model: data one cycle after the request
    always @(negedge clk_sys)
        if (mem_rd_req)
            mem_rd_data <= mem_rd_addr[7:0] ^ 8'hA5;

    // Busy run length and SO activity monitors
    always @(posedge clk_sys)
    begin
        if (spi_so_oe === 1'b1)
            oe_seen = 1'b1;
        if (rst || busy_flag !== 1'b1)
        begin
            if (run > 0)
                last_run = run;
            run = 0;
        end
        else
            run++;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard, about eight times the expected run
    initial
    begin
        #400us;
        n_errors++;
        give_verdict();
    end

    initial
    begin
        rst = 1'b1;
        autosave_nv = 1'b1;
        power_fail = 1'b0;
        mem_wr_ready = 1'b0;
        mem_rd_data = 8'h00;
        n_errors = 0;
        samples_checked = 0;
        run = 0;
        last_run = 0;
        repeat (12) @(negedge clk_sys);
        check("save default", autosave_en, 1'b1);
        check("so idle", spi_so_oe, 1'b0);
        rst = 1'b0;
        repeat (60) @(negedge clk_sys);
        check("powerup len", last_run inside {[39:41]}, 1'b1);
        $display("test powerup done");
        // Bursts from FFFE wrap; fifth byte overflows the FIFO
        for (int m = 0; m < 2; m++)
        begin
            a = m ? 16'h0100 : 16'hFFFE;
            nvr_spi_master_i.frame(m[0], {8'h02, a, 40'h1122334455}, 8, rx);
            check("mode", spi_mode3, m[0]);
            check("overflow", wr_overflow, 1'b1);
            for (int k = 0; k < 4; k++)
            begin
                cnt = 0;
                while (mem_wr_valid !== 1'b1 && cnt++ < 50)
                    @(negedge clk_sys);
                check("wr word", {mem_wr_addr, mem_wr_data},
                      {16'(a + k), 8'(8'h11 * (k + 1))});
                mem_wr_ready = 1'b1;
                @(negedge clk_sys);
                mem_wr_ready = 1'b0;
            end
            repeat (3) @(negedge clk_sys);
            check("fifo empty", mem_wr_valid, 1'b0);
            nvr_spi_master_i.frame(m[0], {8'h03, a, 8'h00}, 4, rx);
            check("rd byte", rx, a[7:0] ^ 8'hA5);
        end
        $display("test memory done");
        // Recall, then a read that breaks the wait on purpose
        nvr_spi_master_i.frame(1'b0, 64'h60, 1, rx);
        check("busy pin", store_busy_pin_oe ? store_busy_pin_o : 1'b1, 1'b0);
        oe_seen = 1'b0;
        nvr_spi_master_i.frame(1'b0, {8'h03, 16'h0005, 8'h00}, 4, rx);
        check("refused read", oe_seen, 1'b0);
        check("recall len", last_run inside {[199:201]}, 1'b1);
        // Host keeps the recall wait, then memory answers again
        repeat (200) @(negedge clk_sys);
        nvr_spi_master_i.frame(1'b0, {8'h03, 16'h0005, 8'h00}, 4, rx);
        check("read after recall", rx, 8'h05 ^ 8'hA5);
        $display("test recall done");
        // Disable, enable, then a second opcode in one select
        for (int i = 0; i < 3; i++)
        begin
            nvr_spi_master_i.frame(1'b0, 64'(ops[i]), i == 2 ? 2 : 1, rx);
            check("save en", autosave_en, i != 0);
            @(negedge clk_sys);
            power_fail = 1'b1;
            cnt = 0;
            repeat (10)
            begin
                @(negedge clk_sys);
                if (autosave_start === 1'b1)
                    cnt = 1;
            end
            check("save start", cnt, i != 0);
            power_fail = 1'b0;
            repeat (5) @(negedge clk_sys);
        end
        $display("test save done");
        oe_seen = 1'b0;
        nvr_spi_master_i.frame(1'b0, {8'hA5, 16'h0000, 8'h00}, 4, rx);
        check("unknown op", oe_seen, 1'b0);
        $display("test unknown done");
        // Power cycle: stored copy now says disabled, recall must rerun
        autosave_nv = 1'b0;
        rst = 1'b1;
        repeat (12) @(negedge clk_sys);
        check("busy in reset", busy_flag, 1'b1);
        rst = 1'b0;
        repeat (60) @(negedge clk_sys);
        check("save reload", autosave_en, 1'b0);
        check("repowerup len", last_run inside {[39:41]}, 1'b1);
        $display("test power cycle done");
        give_verdict();
    end
endmodule
